// [rtl/lcsi_top.sv]
/*
 External second-level cache SRAM interface: address, 64-bit data with odd byte
 parity, select, write enable, two forwarded clocks, feedback clock, sleep enable.
 Assumes a core-side request port on CLOCK and the SRAM side on LINK_CLOCK;
 HARD_RESET_N comes from a pin and is synchronised in the link domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lcsi_defs.svh"

// Notes on behaviour
// - sram_addr is 17 bits, bit 0 least significant, bit 16 most significant.
// - address bit 14 selects the cache tag set.
// - address valid during accesses, held static otherwise.
// - data bus is 64 bits, every transfer a full double word.
// - write data driven on writes, bus static when no read in progress.
// - data and parity left undriven one cycle when switching read and write.
// - writes carry one odd parity bit per data byte.
// - parity bit 0 covers data bits 0-7, higher bits the next lanes.
// - sram_select low for each access, high otherwise and during hard reset.
// - sram_write_n low only on writes, high during hard reset.
// - both SRAM clocks identical by default.
// - differential mode drives clock b as inverse of clock a.
// - both SRAM clocks held low during hard reset.
// - addressing covers up to 1 Mbyte of SRAM.
// - parity lines and sleep enable are optional per fitted SRAM.
// - sleep enable changes on SRAM clock; two cycles before accesses resume.
// - feedback clock output held low during hard reset.
module lcsi_top
   import lcsi_pkg::*;
#(
   parameter int ADDR_W = `LCSI_ADDR_W,
   parameter int DATA_W = `LCSI_DATA_W,
   parameter int LANES  = `LCSI_LANES
) (
   // core clock and reset
   input  wire logic                CLOCK,
   input  wire logic                SRST,
   input  wire logic                CE,
   // link clock and hard reset pin
   input  wire logic                LINK_CLOCK,
   input  wire logic                HARD_RESET_N,
   // configuration
   input  wire logic                DIFF_CLOCK_EN,
   input  wire logic                PARITY_EN,
   input  wire logic                SLEEP_USE_EN,
   input  wire logic                SLEEP_REQ,
   // core request
   input  wire logic                REQ_VALID,
   output logic                     REQ_READY,
   input  wire lcsi_pkg::lcsi_op_t  REQ_OP,
   input  wire logic [ADDR_W-1:0]   REQ_ADDR,
   input  wire logic [DATA_W-1:0]   REQ_WDATA,
   // core answer
   output logic                     RSP_VALID,
   output logic [DATA_W-1:0]        RSP_RDATA,
   output logic                     RSP_PERR,
   output logic                     SLEEPING,
   // sram pins
   output logic [ADDR_W-1:0]        SRAM_ADDR,
   input  wire logic [DATA_W-1:0]   SRAM_DATA_I,
   output logic [DATA_W-1:0]        SRAM_DATA_O,
   output logic                     SRAM_DATA_OE,
   input  wire logic [LANES-1:0]    SRAM_PARITY_I,
   output logic [LANES-1:0]         SRAM_PARITY_O,
   output logic                     SRAM_PARITY_OE,
   output logic                     SRAM_SELECT_N,
   output logic                     SRAM_WRITE_N,
   output logic                     SRAM_CLOCK_A,
   output logic                     SRAM_CLOCK_B,
   output logic                     SRAM_CLOCK_FEEDBACK_OUT,
   output logic                     SRAM_SLEEP_ENABLE
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam int WAKE = `LCSI_WAKE_CYC;

   lcsi_state_t          st_reg;
   lcsi_state_t          st_next;
   logic                 hr_sync;
   logic                 in_reset;
   logic                 cfg_diff;
   logic                 cfg_par;
   logic                 cfg_slp;
   logic                 slp_req;
   logic                 req_tgl_reg;
   logic                 req_tgl_l;
   logic                 req_seen_reg;
   logic                 ack_tgl_reg;
   logic                 ack_tgl_c;
   logic                 ack_seen_reg;
   logic                 busy_reg;
   lcsi_op_t             op_hold_reg;
   logic [ADDR_W-1:0]    addr_hold_reg;
   logic [DATA_W-1:0]    wdata_hold_reg;
   logic                 last_wr_reg;
   logic                 rd_cap_reg;
   logic [DATA_W-1:0]    rdata_reg;
   logic                 perr_reg;
   logic [1:0]           wake_cnt_reg;
   logic                 new_req;
   logic                 clk_phase_reg;
   logic                 slp_out_reg;

   // ----------------------------------------------------------------
   // core domain: request capture and answer
   // ----------------------------------------------------------------
   // one request in flight; its words stay stable until the link acks
   assign REQ_READY = CE && !busy_reg && (REQ_OP != LCSI_OP_NONE);

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         busy_reg       <= 1'b0;
         req_tgl_reg    <= 1'b0;
         op_hold_reg    <= LCSI_OP_NONE;
         addr_hold_reg  <= '0;
         wdata_hold_reg <= '0;
      end else if (CE) begin
         if (REQ_VALID && REQ_READY) begin
            busy_reg       <= 1'b1;
            req_tgl_reg    <= ~req_tgl_reg;
            op_hold_reg    <= REQ_OP;
            addr_hold_reg  <= REQ_ADDR;
            wdata_hold_reg <= REQ_WDATA;
         end else if (ack_tgl_c != ack_seen_reg) begin
            busy_reg <= 1'b0;
         end
      end
   end

   lcsi_sync #(.W(1)) u_ack_sync (
      .clk  (CLOCK),
      .srst (SRST),
      .ce   (CE),
      .d    (ack_tgl_reg),
      .q    (ack_tgl_c)
   );

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ack_seen_reg <= 1'b0;
         RSP_VALID    <= 1'b0;
         RSP_RDATA    <= '0;
         RSP_PERR     <= 1'b0;
      end else if (CE) begin
         ack_seen_reg <= ack_tgl_c;
         RSP_VALID    <= ack_tgl_c != ack_seen_reg;
         if (ack_tgl_c != ack_seen_reg) begin
            RSP_RDATA <= rdata_reg;
            RSP_PERR  <= perr_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // link domain: synchronisers
   // ----------------------------------------------------------------
   lcsi_sync #(.W(6)) u_link_sync (
      .clk  (LINK_CLOCK),
      .srst (SRST),
      .ce   (CE),
      .d    ({HARD_RESET_N, DIFF_CLOCK_EN, PARITY_EN, SLEEP_USE_EN, SLEEP_REQ,
              req_tgl_reg}),
      .q    ({hr_sync, cfg_diff, cfg_par, cfg_slp, slp_req, req_tgl_l})
   );

   assign in_reset = !hr_sync;
   assign new_req  = req_tgl_l != req_seen_reg;

   // ----------------------------------------------------------------
   // link domain: access sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         LCSI_ST_IDLE: begin
            if (cfg_slp && slp_req)
               st_next = LCSI_ST_SLEEP;
            else if (new_req && (op_hold_reg == LCSI_OP_WRITE) != last_wr_reg)
               st_next = LCSI_ST_TURN;
            else if (new_req)
               st_next = (op_hold_reg == LCSI_OP_WRITE) ? LCSI_ST_WRITE : LCSI_ST_READ;
         end
         LCSI_ST_TURN:
            st_next = (op_hold_reg == LCSI_OP_WRITE) ? LCSI_ST_WRITE : LCSI_ST_READ;
         LCSI_ST_READ:  st_next = LCSI_ST_IDLE;
         LCSI_ST_WRITE: st_next = LCSI_ST_IDLE;
         LCSI_ST_SLEEP: if (!(cfg_slp && slp_req)) st_next = LCSI_ST_WAKE;
         LCSI_ST_WAKE:  if (wake_cnt_reg == 2'(WAKE - 1)) st_next = LCSI_ST_IDLE;
      endcase
   end

   // hard reset keeps the toggle pair and a pending capture, so a request caught
   // by it is still answered after release and the core never stays busy
   always_ff @(posedge LINK_CLOCK) begin
      if (SRST) begin
         st_reg       <= LCSI_ST_IDLE;
         req_seen_reg <= 1'b0;
         ack_tgl_reg  <= 1'b0;
         last_wr_reg  <= 1'b0;
         wake_cnt_reg <= '0;
         rd_cap_reg   <= 1'b0;
      end else if (in_reset) begin
         st_reg       <= LCSI_ST_IDLE;
         last_wr_reg  <= 1'b0;
         wake_cnt_reg <= '0;
      end else if (CE) begin
         st_reg <= st_next;
         wake_cnt_reg <= (st_reg == LCSI_ST_WAKE) ? wake_cnt_reg + 2'h1 : 2'h0;
         rd_cap_reg   <= st_reg == LCSI_ST_READ;
         if (st_reg == LCSI_ST_READ || st_reg == LCSI_ST_WRITE) begin
            req_seen_reg <= req_tgl_l;
            last_wr_reg  <= st_reg == LCSI_ST_WRITE;
         end
         // a read is answered only once its word has been taken
         if (st_reg == LCSI_ST_WRITE || rd_cap_reg)
            ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   // ----------------------------------------------------------------
   // link domain: pin registers
   // ----------------------------------------------------------------
   // address stays at its last value between accesses to keep pins quiet
   always_ff @(posedge LINK_CLOCK) begin
      if (SRST || in_reset) begin
         SRAM_ADDR      <= '0;
         SRAM_SELECT_N  <= 1'b1;
         SRAM_WRITE_N   <= 1'b1;
         SRAM_DATA_O    <= '0;
         SRAM_DATA_OE   <= 1'b0;
         SRAM_PARITY_O  <= '0;
         SRAM_PARITY_OE <= 1'b0;
      end else if (CE) begin
         SRAM_SELECT_N <= !(st_next == LCSI_ST_READ || st_next == LCSI_ST_WRITE);
         SRAM_WRITE_N  <= st_next != LCSI_ST_WRITE;
         if (st_next == LCSI_ST_READ || st_next == LCSI_ST_WRITE)
            SRAM_ADDR <= addr_hold_reg;
         if (st_next == LCSI_ST_WRITE) begin
            SRAM_DATA_O <= wdata_hold_reg;
            for (int i = 0; i < LANES; i++)
               SRAM_PARITY_O[i] <= ~^wdata_hold_reg[8*i +: 8];
         end
         // write side keeps driving static data until a read needs the bus
         if (st_next == LCSI_ST_WRITE) begin
            SRAM_DATA_OE   <= 1'b1;
            SRAM_PARITY_OE <= cfg_par;
         end else if (st_next == LCSI_ST_TURN || st_next == LCSI_ST_READ) begin
            SRAM_DATA_OE   <= 1'b0;
            SRAM_PARITY_OE <= 1'b0;
         end
      end
   end

   // flow-through sram: it takes select at the edge ending the select cycle and
   // shows the word before the next edge, so data and parity are taken there
   always_ff @(posedge LINK_CLOCK) begin
      if (SRST || in_reset) begin
         rdata_reg  <= '0;
         perr_reg   <= 1'b0;
      end else if (CE) begin
         if (rd_cap_reg) begin
            rdata_reg <= SRAM_DATA_I;
            perr_reg  <= 1'b0;
            for (int i = 0; i < LANES; i++)
               if (cfg_par && !(^{SRAM_DATA_I[8*i +: 8], SRAM_PARITY_I[i]}))
                  perr_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // forwarded clocks and sleep enable
   // ----------------------------------------------------------------
   // clocks are divided by two from the link clock: glitch free, half rate
   always_ff @(posedge LINK_CLOCK) begin
      if (SRST || in_reset) begin
         clk_phase_reg           <= 1'b0;
         SRAM_CLOCK_A            <= 1'b0;
         SRAM_CLOCK_B            <= 1'b0;
         SRAM_CLOCK_FEEDBACK_OUT <= 1'b0;
      end else if (CE) begin
         clk_phase_reg           <= ~clk_phase_reg;
         SRAM_CLOCK_A            <= ~clk_phase_reg;
         SRAM_CLOCK_B            <= cfg_diff ? clk_phase_reg : ~clk_phase_reg;
         SRAM_CLOCK_FEEDBACK_OUT <= ~clk_phase_reg;
      end
   end

   always_ff @(posedge LINK_CLOCK) begin
      if (SRST || in_reset) begin
         slp_out_reg <= 1'b0;
      end else if (CE) begin
         slp_out_reg <= st_next == LCSI_ST_SLEEP;
      end
   end

   assign SRAM_SLEEP_ENABLE = slp_out_reg;
   assign SLEEPING          = slp_out_reg;
endmodule : lcsi_top
`default_nettype wire

// [rtl/lcsi_defs.svh]
/*
 Constants of the external cache SRAM interface: widths, timing counts, flag positions.
 Assumes inclusion by bare name from any file of the block.
*/
`ifndef LCSI_DEFS_SVH
`define LCSI_DEFS_SVH

`define LCSI_ADDR_W      17
`define LCSI_ADDR_MSB    16
`define LCSI_ADDR_LSB    0
`define LCSI_TAGSET_BIT  14
`define LCSI_DATA_W      64
`define LCSI_LANES       8
`define LCSI_TURN_CYC    1
`define LCSI_WAKE_CYC    2
`define LCSI_MEM_BYTES   1048576

`endif

// [rtl/lcsi_pkg.sv]
/*
 Types of the external cache SRAM interface.
 Assumes nothing beyond the defs header.
*/
package lcsi_pkg;
   typedef enum logic [1:0] {
      LCSI_OP_NONE,
      LCSI_OP_READ,
      LCSI_OP_WRITE
   } lcsi_op_t;
   typedef enum {
      LCSI_ST_IDLE,
      LCSI_ST_READ,
      LCSI_ST_WRITE,
      LCSI_ST_TURN,
      LCSI_ST_SLEEP,
      LCSI_ST_WAKE
   } lcsi_state_t;
endpackage : lcsi_pkg

// [rtl/lcsi_sync.sv]
/*
 Two flip-flop level synchroniser.
 Assumes the destination clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module lcsi_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   // level in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // first stage is read by the second stage only
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         q        <= '0;
      end else if (ce) begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : lcsi_sync
`default_nettype wire

// [dv/lcsi_assertions.sv]
/*
 Pin and core handshake checks of the cache SRAM interface.
 Assumes a bind into lcsi_top; sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module lcsi_assertions #(
   parameter int ADDR_W = 17,
   parameter int DATA_W = 64,
   parameter int LANES  = 8
) (
   // clocks, reset, configuration, core handshake
   input wire logic              CLOCK,
   input wire logic              SRST,
   input wire logic              LINK_CLOCK,
   input wire logic              HARD_RESET_N,
   input wire logic              DIFF_CLOCK_EN,
   input wire logic              REQ_VALID,
   input wire logic              REQ_READY,
   input wire logic              RSP_VALID,
   // sram pins
   input wire logic [ADDR_W-1:0] SRAM_ADDR,
   input wire logic [DATA_W-1:0] SRAM_DATA_O,
   input wire logic              SRAM_DATA_OE,
   input wire logic [LANES-1:0]  SRAM_PARITY_O,
   input wire logic              SRAM_PARITY_OE,
   input wire logic              SRAM_SELECT_N,
   input wire logic              SRAM_WRITE_N,
   input wire logic              SRAM_CLOCK_A,
   input wire logic              SRAM_CLOCK_B,
   input wire logic              SRAM_CLOCK_FEEDBACK_OUT,
   input wire logic              SRAM_SLEEP_ENABLE
);
   logic par_ok;
   always_comb begin
      par_ok = 1'b1;
      for (int i = 0; i < LANES; i++) begin
         par_ok = par_ok & (^{SRAM_DATA_O[8*i+:8], SRAM_PARITY_O[i]});
      end
   end
   a_par_odd: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      !SRAM_SELECT_N && !SRAM_WRITE_N && SRAM_PARITY_OE |-> par_ok) else $error("write parity");
   a_read_free: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      !SRAM_SELECT_N && SRAM_WRITE_N |-> (!SRAM_DATA_OE && !SRAM_PARITY_OE) [*2])
      else $error("read driven");
   a_turn_gap: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      !SRAM_SELECT_N && SRAM_WRITE_N |-> !$past(SRAM_DATA_OE)) else $error("no turnaround");
   a_write_sel: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      !SRAM_WRITE_N |-> !SRAM_SELECT_N && SRAM_DATA_OE) else $error("stray write");
   a_clk_same: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      !DIFF_CLOCK_EN && !$past(DIFF_CLOCK_EN, 4) |-> SRAM_CLOCK_B == SRAM_CLOCK_A)
      else $error("clocks differ");
   a_hard_reset_n_idle: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      !HARD_RESET_N [*6] |-> SRAM_SELECT_N && SRAM_WRITE_N && !SRAM_CLOCK_A && !SRAM_CLOCK_B
      && !SRAM_CLOCK_FEEDBACK_OUT && !SRAM_SLEEP_ENABLE) else $error("hard reset levels");
   a_wake_gap: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      $fell(SRAM_SLEEP_ENABLE) |-> SRAM_SELECT_N [*2]) else $error("early access");
   a_addr_static: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      SRAM_SELECT_N && HARD_RESET_N |-> $stable(SRAM_ADDR)) else $error("address moved");
   a_data_static: assert property (@(posedge LINK_CLOCK) disable iff (SRST)
      SRAM_WRITE_N && HARD_RESET_N |-> $stable(SRAM_DATA_O)) else $error("data moved");
   a_answer_due: assert property (@(posedge CLOCK) disable iff (SRST)
      REQ_VALID && REQ_READY |-> ##[1:40] RSP_VALID) else $error("no answer");
endmodule : lcsi_assertions
`default_nettype wire

// [dv/lcsi_sram_model.sv]
/*
 Behavioural model of the external synchronous SRAM.
 Assumes select and write strobes active low, sampled on the link clock.
*/
`timescale 1ns/10ps
`default_nettype none
module lcsi_sram_model (
   // link side
   input  wire logic        clk,
   input  wire logic        bad_par,
   // sram pins
   input  wire logic        sel_n,
   input  wire logic        we_n,
   input  wire logic [16:0] addr,
   input  wire logic [63:0] din,
   output logic      [63:0] dout,
   output logic      [7:0]  pout
);
   bit   [63:0] mem [0:131071];
   logic [63:0] q = 64'h0;
   logic        rd = 1'b0;
   logic [7:0]  par;
   // samples on the link clock, not the divided sram clock: simpler, twice as many rising edges
   always @(posedge clk) begin
      rd <= !sel_n && we_n;
      if (!sel_n && !we_n) mem[addr] = din;
      if (!sel_n && we_n) q <= mem[addr];
   end
   always_comb begin
      for (int i = 0; i < 8; i++) par[i] = ~^q[8*i+:8];
   end
   // released bus shows the inverse of the last word, never a held copy
   assign dout = rd ? q : ~q;
   assign pout = rd ? par ^ {8{bad_par}} : ~par;
endmodule : lcsi_sram_model
`default_nettype wire

// [dv/lcsi_top_test.sv]
/*
 Self-checking bench of the cache SRAM interface with an SRAM model.
 Assumes design, model and checker compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module lcsi_top_test;
   import lcsi_pkg::*;
   logic CLOCK = 0, SRST = 1, CE = 1, LINK_CLOCK = 0, HARD_RESET_N = 1, bad_par = 0;
   logic DIFF_CLOCK_EN = 0, PARITY_EN = 1, SLEEP_USE_EN = 1, SLEEP_REQ = 0, REQ_VALID = 0;
   lcsi_op_t REQ_OP = LCSI_OP_NONE;
   logic [16:0] REQ_ADDR = '0, SRAM_ADDR;
   logic [63:0] REQ_WDATA = '0, RSP_RDATA, SRAM_DATA_I, SRAM_DATA_O, mdl_data;
   logic [7:0] SRAM_PARITY_I, SRAM_PARITY_O, mdl_par;
   logic REQ_READY, RSP_VALID, RSP_PERR, SLEEPING, SRAM_DATA_OE, SRAM_PARITY_OE;
   logic SRAM_SELECT_N, SRAM_WRITE_N, SRAM_CLOCK_A, SRAM_CLOCK_B;
   logic SRAM_CLOCK_FEEDBACK_OUT, SRAM_SLEEP_ENABLE;
   logic [5:0] idle;
   int bad_count = 0, n_tests = 0;
   always #10 CLOCK = ~CLOCK;
   initial begin
      #3;
      forever begin
         LINK_CLOCK = ~LINK_CLOCK;
         #40;
      end
   end
   assign SRAM_DATA_I = SRAM_DATA_OE ? SRAM_DATA_O : mdl_data;
   assign SRAM_PARITY_I = SRAM_PARITY_OE ? SRAM_PARITY_O : mdl_par;
   lcsi_top dut_u (.CLOCK, .SRST, .CE, .LINK_CLOCK, .HARD_RESET_N, .DIFF_CLOCK_EN, .PARITY_EN,
      .SLEEP_USE_EN, .SLEEP_REQ, .REQ_VALID, .REQ_READY, .REQ_OP, .REQ_ADDR, .REQ_WDATA,
      .RSP_VALID, .RSP_RDATA, .RSP_PERR, .SLEEPING, .SRAM_ADDR, .SRAM_DATA_I, .SRAM_DATA_O,
      .SRAM_DATA_OE, .SRAM_PARITY_I, .SRAM_PARITY_O, .SRAM_PARITY_OE, .SRAM_SELECT_N,
      .SRAM_WRITE_N, .SRAM_CLOCK_A, .SRAM_CLOCK_B, .SRAM_CLOCK_FEEDBACK_OUT, .SRAM_SLEEP_ENABLE);
   lcsi_sram_model mdl_u (.clk(LINK_CLOCK), .bad_par, .sel_n(SRAM_SELECT_N),
      .we_n(SRAM_WRITE_N), .addr(SRAM_ADDR), .din(SRAM_DATA_I), .dout(mdl_data), .pout(mdl_par));
   task report_and_stop;
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   task check(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         bad_count++;
      end
   endtask : check
   task hang;
      bad_count++;
      report_and_stop();
   endtask : hang
   // request held from a falling edge through the taking edge
   task xfer(input lcsi_op_t op, input logic [16:0] a, input logic [63:0] d);
      int i;
      REQ_OP = op;
      REQ_ADDR = a;
      REQ_WDATA = d;
      REQ_VALID = 1'b1;
      for (i = 0; i < 99 && REQ_READY !== 1'b1; i++) @(negedge CLOCK);
      if (REQ_READY !== 1'b1) hang();
      @(negedge CLOCK);
      REQ_VALID = 1'b0;
      for (i = 0; i < 99 && RSP_VALID !== 1'b1; i++) @(negedge CLOCK);
      if (RSP_VALID !== 1'b1) hang();
   endtask : xfer
   // write and read interleaved, then reads only: both turnarounds, no aliasing
   task t_write_read;
      logic [16:0] a [4];
      logic [63:0] d;
      a = '{17'h00000, 17'h04000, 17'h10000, 17'h1FFFF};
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            d = 64'h0123456789ABCDEF ^ {47'h0, a[k]};
            if (p == 0) xfer(LCSI_OP_WRITE, a[k], d);
            xfer(LCSI_OP_READ, a[k], 64'h0);
            check("read data", d, RSP_RDATA);
            check("parity error", 64'h0, {63'h0, RSP_PERR});
         end
      end
   endtask : t_write_read
   task t_parity;
      bad_par = 1'b1;
      xfer(LCSI_OP_READ, 17'h04000, 64'h0);
      check("parity error", 64'h1, {63'h0, RSP_PERR});
      PARITY_EN = 1'b0;
      repeat (12) @(negedge CLOCK);
      xfer(LCSI_OP_WRITE, 17'h00000, 64'hFFFFFFFFFFFFFFFF);
      xfer(LCSI_OP_READ, 17'h00000, 64'h0);
      check("parity error", 64'h0, {63'h0, RSP_PERR});
      check("read data", 64'hFFFFFFFFFFFFFFFF, RSP_RDATA);
      bad_par = 1'b0;
      PARITY_EN = 1'b1;
      repeat (12) @(negedge CLOCK);
   endtask : t_parity
   // clock a must move once in any 80 ns and stand still while CE is low
   task t_clocks;
      logic a0;
      DIFF_CLOCK_EN = 1'b1;
      repeat (20) @(negedge CLOCK);
      check("clock b", {63'h0, !SRAM_CLOCK_A}, {63'h0, SRAM_CLOCK_B});
      DIFF_CLOCK_EN = 1'b0;
      repeat (20) @(negedge CLOCK);
      check("clock b", {63'h0, SRAM_CLOCK_A}, {63'h0, SRAM_CLOCK_B});
      check("feedback", {63'h0, SRAM_CLOCK_A}, {63'h0, SRAM_CLOCK_FEEDBACK_OUT});
      a0 = SRAM_CLOCK_A;
      repeat (4) @(negedge CLOCK);
      check("clock a", {63'h0, !a0}, {63'h0, SRAM_CLOCK_A});
      CE = 1'b0;
      a0 = SRAM_CLOCK_A;
      repeat (8) @(negedge CLOCK);
      check("frozen clock a", {63'h0, a0}, {63'h0, SRAM_CLOCK_A});
      CE = 1'b1;
   endtask : t_clocks
   task t_sleep;
      SLEEP_USE_EN = 1'b0;
      SLEEP_REQ = 1'b1;
      repeat (12) @(negedge CLOCK);
      check("sleep unused", 64'h0, {63'h0, SLEEPING});
      SLEEP_USE_EN = 1'b1;
      for (int i = 0; i < 99 && SLEEPING !== 1'b1; i++) @(negedge CLOCK);
      if (SLEEPING !== 1'b1) hang();
      check("sleep enable", 64'h1, {63'h0, SRAM_SLEEP_ENABLE});
      SLEEP_REQ = 1'b0;
      xfer(LCSI_OP_READ, 17'h00000, 64'h0);
      check("read data", 64'hFFFFFFFFFFFFFFFF, RSP_RDATA);
   endtask : t_sleep
   task t_hard_reset;
      HARD_RESET_N = 1'b0;
      repeat (20) @(negedge CLOCK);
      idle = {SRAM_SELECT_N, SRAM_WRITE_N, SRAM_CLOCK_A, SRAM_CLOCK_B,
         SRAM_CLOCK_FEEDBACK_OUT, SRAM_SLEEP_ENABLE};
      check("idle pins", 64'h30, {58'h0, idle});
      HARD_RESET_N = 1'b1;
      repeat (20) @(negedge CLOCK);
      xfer(LCSI_OP_READ, 17'h00000, 64'h0);
      check("read after reset", 64'hFFFFFFFFFFFFFFFF, RSP_RDATA);
   endtask : t_hard_reset
   initial begin
      repeat (10) @(negedge CLOCK);
      SRST = 1'b0;
      t_write_read();
      t_parity();
      t_clocks();
      t_sleep();
      t_hard_reset();
      report_and_stop();
   end
endmodule : lcsi_top_test
bind lcsi_top lcsi_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) chk_u (
   .CLOCK, .SRST, .LINK_CLOCK, .HARD_RESET_N, .DIFF_CLOCK_EN, .REQ_VALID, .REQ_READY,
   .RSP_VALID, .SRAM_ADDR,
   .SRAM_DATA_O, .SRAM_DATA_OE, .SRAM_PARITY_O, .SRAM_PARITY_OE, .SRAM_SELECT_N,
   .SRAM_WRITE_N, .SRAM_CLOCK_A, .SRAM_CLOCK_B, .SRAM_CLOCK_FEEDBACK_OUT, .SRAM_SLEEP_ENABLE);
`default_nettype wire
